//--- rtl/vtm_sequencer.sv
// Voltage and temperature monitor sequencer with its register slave.
`timescale 1ns/1ns
`default_nettype none
`include "vtm_regs.svh"
module vtm_sequencer #(
   parameter int unsigned SLOT_CYC = `VTM_SLOT_US * `VTM_CLK_MHZ
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Register bus.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Reset sequencer status.
   input  wire logic        normal_mode,
   // Converter front end.
   output var  logic [1:0]  sense_sel,
   output var  logic        conv_start,
   input  wire logic        sense_done,
   input  wire logic [7:0]  sense_data,
   // Pin routing, alarms to the link, interrupt.
   output var  logic [3:0]  pin_sense_route,
   output var  logic [2:0]  alarm,
   output var  logic        irq
);
   localparam int NS = `VTM_NSRC;

   vtm_pkg::vtm_state_s st_q;
   vtm_pkg::vtm_state_s st_d;

   logic          tick;
   logic [7:0]    idx;
   logic          hit;
   logic          acc;
   logic          wr;
   logic          any_en;
   logic          go;
   logic [NS-1:0] oor;
   logic [1:0]    nxt;

   // Next enabled source after cur, wrapping round to the first.
   function automatic logic [1:0] next_src(input logic [1:0] cur,
                                          input logic [NS-1:0] en);
      logic [1:0] c;
      logic [1:0] r;
      c = cur;
      r = cur;
      for (int k = 0; k < NS; k++) begin
         c = (c == 2'(NS - 1)) ? 2'h0 : c + 2'h1;
         if (en[c] && r == cur) begin
            r = c;
         end
      end
      if (!en[cur] && r == cur) begin
         r = 2'h0;
      end
      return r;
   endfunction : next_src

   function automatic logic [31:0] rd_mux(input vtm_pkg::vtm_state_s s,
                                          input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      case (a)
         `VTM_IDX_CTRL: begin
            v[`VTM_CTRL_EN] = s.mon_en;
            v[`VTM_CTRL_SRC +: NS] = s.src_en;
            v[`VTM_CTRL_CUR +: 2] = s.src;
            v[`VTM_CTRL_RUN] = (s.fsm != vtm_pkg::VTM_OFF);
         end
         `VTM_IDX_LIM0: v[15:0] = {s.lim_hi[0], s.lim_lo[0]};
         `VTM_IDX_LIM1: v[15:0] = {s.lim_hi[1], s.lim_lo[1]};
         `VTM_IDX_LIMT: v[15:0] = {s.lim_hi[2], s.lim_lo[2]};
         `VTM_IDX_ALARM: v[NS-1:0] = s.sts;
         `VTM_IDX_READ: v[23:0] = s.rd;
         `VTM_IDX_MASK: v[NS-1:0] = s.mask;
         default: v = '0;
      endcase
      return v;
   endfunction : rd_mux

   vtm_slot_timer #(
      .SLOT_CYC (SLOT_CYC)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (st_q.fsm != vtm_pkg::VTM_OFF),
      .tick    (tick)
   );

   // The register file answers at byte address four times its index.
   assign idx = paddr[9:2];
   assign hit = (paddr[11:10] == 2'h0) && (idx >= `VTM_IDX_CTRL)
             && (idx <= `VTM_IDX_MASK);
   // One wait state; writes act at the edge that completes the access.
   assign acc = psel && penable && st_q.pready;
   assign wr  = acc && pwrite && hit;
   assign any_en = |st_q.src_en;
   assign go  = st_q.mon_en && normal_mode && any_en;
   assign nxt = next_src(st_q.src, st_q.src_en);

   // Each source checks a fresh reading against its own pair of limits.
   for (genvar i = 0; i < NS; i++) begin : g_cmp
      assign oor[i] = sense_done && st_q.fsm == vtm_pkg::VTM_MEAS
                   && st_q.src == 2'(i)
                   && (sense_data < st_q.lim_lo[i]
                       || sense_data > st_q.lim_hi[i]);
   end

   always_comb begin
      st_d = st_q;
      st_d.conv = 1'b0;
      // Register bus.
      if (psel && penable && !st_q.pready) begin
         st_d.pready  = 1'b1;
         st_d.pslverr = !hit;
         st_d.prdata  = hit ? rd_mux(st_q, idx) : '0;
      end else begin
         st_d.pready  = 1'b0;
         st_d.pslverr = 1'b0;
      end
      if (wr) begin
         case (idx)
            `VTM_IDX_CTRL: begin
               st_d.mon_en = pwdata[`VTM_CTRL_EN];
               st_d.src_en = pwdata[`VTM_CTRL_SRC +: NS];
            end
            `VTM_IDX_LIM0: begin
               st_d.lim_lo[0] = pwdata[7:0];
               st_d.lim_hi[0] = pwdata[`VTM_LIM_HI +: 8];
            end
            `VTM_IDX_LIM1: begin
               st_d.lim_lo[1] = pwdata[7:0];
               st_d.lim_hi[1] = pwdata[`VTM_LIM_HI +: 8];
            end
            `VTM_IDX_LIMT: begin
               st_d.lim_lo[2] = pwdata[7:0];
               st_d.lim_hi[2] = pwdata[`VTM_LIM_HI +: 8];
            end
            `VTM_IDX_ALARM: st_d.sts = st_q.sts & ~pwdata[NS-1:0];
            `VTM_IDX_MASK: st_d.mask = pwdata[NS-1:0];
            default: st_d.mask = st_q.mask;
         endcase
      end
      // An alarm raised in the clearing cycle survives the clear.
      st_d.sts = st_d.sts | oor;
      // Sequencing.
      case (st_q.fsm)
         vtm_pkg::VTM_OFF: begin
            if (go) begin
               st_d.src = next_src(2'(NS - 1), st_q.src_en);
               st_d.fsm = vtm_pkg::VTM_START;
            end
         end
         vtm_pkg::VTM_START: begin
            // A start cut short by a dropped enable must not convert.
            st_d.conv = go;
            st_d.fsm  = go ? vtm_pkg::VTM_MEAS : vtm_pkg::VTM_OFF;
         end
         vtm_pkg::VTM_MEAS: begin
            if (sense_done) begin
               st_d.rd[st_q.src] = sense_data;
            end
            if (!go) begin
               st_d.fsm = vtm_pkg::VTM_OFF;
            end else if (tick) begin
               st_d.src  = nxt;
               st_d.conv = 1'b1;
            end
         end
         default: st_d.fsm = vtm_pkg::VTM_OFF;
      endcase
      st_d.irq = |(st_d.sts & st_d.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q        <= '0;
         st_q.fsm    <= vtm_pkg::VTM_OFF;
         st_q.src_en <= `VTM_RST_SRC_EN;
         st_q.route  <= `VTM_RST_ROUTE;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata          = st_q.prdata;
   assign pready          = st_q.pready;
   assign pslverr         = st_q.pslverr;
   assign sense_sel       = st_q.src;
   assign conv_start      = st_q.conv;
   assign pin_sense_route = st_q.route;
   assign alarm           = st_q.sts;
   assign irq             = st_q.irq;

   // Helper: source of the previous conversion, for the rotation check.
   logic [1:0] prev_q;
   logic       prev_v_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q   <= 2'h0;
         prev_v_q <= 1'b0;
      end else if (st_q.fsm == vtm_pkg::VTM_OFF) begin
         prev_v_q <= 1'b0;
      end else if (st_q.conv) begin
         prev_q   <= st_q.src;
         prev_v_q <= 1'b1;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_one_wait: assert property (
      psel && penable && !pready |=> pready)
      else $error("register access did not complete after one wait");

   a_hold_not_normal: assert property (
      !normal_mode |=> st_q.fsm == vtm_pkg::VTM_OFF && !conv_start)
      else $error("monitor ran outside normal mode");

   a_off_disabled: assert property (
      !st_q.mon_en |=> st_q.fsm == vtm_pkg::VTM_OFF)
      else $error("monitor ran while not enabled");

   a_slot_next: assert property (
      st_q.fsm == vtm_pkg::VTM_MEAS && tick && go
      |=> conv_start && sense_sel == $past(nxt))
      else $error("slot end did not start the next source");

   a_skip_disabled: assert property (
      conv_start |-> st_q.src_en[sense_sel])
      else $error("disabled source was measured");

   a_rotate_order: assert property (
      conv_start && prev_v_q && $stable(st_q.src_en)
      |-> sense_sel == next_src(prev_q, st_q.src_en))
      else $error("rotation order broken");

   a_reading_kept: assert property (
      sense_done && st_q.fsm == vtm_pkg::VTM_MEAS
      |=> st_q.rd[$past(st_q.src)] == $past(sense_data))
      else $error("reading not stored");

   a_volt_alarm: assert property (
      sense_done && st_q.fsm == vtm_pkg::VTM_MEAS && st_q.src != 2'h2
      && sense_data > st_q.lim_hi[st_q.src]
      |=> alarm[$past(st_q.src)] ##1 alarm[$past(st_q.src, 2)])
      else $error("pin alarm not raised");

   a_temp_alarm: assert property (
      sense_done && st_q.fsm == vtm_pkg::VTM_MEAS
      && st_q.src == `VTM_SRC_TEMP && sense_data < st_q.lim_lo[2]
      |=> alarm[2])
      else $error("temperature alarm not raised");

   a_limit_pair: assert property (
      wr && idx == `VTM_IDX_LIM1
      |=> st_q.lim_lo[1] == $past(pwdata[7:0])
          && st_q.lim_hi[1] == $past(pwdata[15:8]))
      else $error("pin limits not written");

   a_pin_route: assert property (
      pin_sense_route == `VTM_RST_ROUTE)
      else $error("sense pin routing changed");

   a_irq_level: assert property (
      irq == (|(alarm & st_q.mask)))
      else $error("interrupt level does not follow unmasked alarms");

   c_three_slots: cover property (
      conv_start && sense_sel == 2'h0 && st_q.src_en == 3'h7);
   c_two_slots: cover property (
      conv_start && sense_sel == 2'h2 && st_q.src_en == 3'h5);
   c_alarm_clear: cover property (wr && idx == `VTM_IDX_ALARM && |alarm);
   c_irq: cover property ($rose(irq));
   c_temp_alarm: cover property ($rose(alarm[2]));

   // Bus answers, slot timing and alarm bookkeeping.
   a_err_unmapped: assert property (
      psel && penable && !pready && !hit |=> pslverr)
      else $error("unmapped access not flagged");

   a_ok_mapped: assert property (
      psel && penable && !pready && hit |=> !pslverr)
      else $error("mapped access flagged as error");

   a_err_no_data: assert property (
      pslverr |-> prdata == 32'h0000_0000)
      else $error("unmapped access returned data");

   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   a_sel_held: assert property (
      st_q.fsm == vtm_pkg::VTM_MEAS && !tick |=> $stable(sense_sel))
      else $error("source changed inside a slot");

   a_conv_in_meas: assert property (
      conv_start |-> st_q.fsm == vtm_pkg::VTM_MEAS)
      else $error("conversion started outside measuring");

   a_conv_pulse: assert property (
      conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");

   a_start_entry: assert property (
      st_q.fsm == vtm_pkg::VTM_OFF && go |=> st_q.fsm == vtm_pkg::VTM_START)
      else $error("monitor did not start when allowed");

   a_alarm_sticky: assert property (
      !(wr && idx == `VTM_IDX_ALARM)
      |=> (alarm & $past(alarm)) == $past(alarm))
      else $error("alarm bit dropped without a clear");

   a_no_stray_alarm: assert property (
      !sense_done |=> (alarm & ~$past(alarm)) == 3'h0)
      else $error("alarm set without a reading");

   a_reading_idle: assert property (
      !(sense_done && st_q.fsm == vtm_pkg::VTM_MEAS) |=> $stable(st_q.rd))
      else $error("reading changed without a conversion");
endmodule : vtm_sequencer
`default_nettype wire

//--- pkg/vtm_regs.svh
// Register indices, field positions, reset values and timing constants.
//
// What this block does
// - Sources are measured one after another in a fixed rotating order.
// - No measurement starts before the reset sequencer reaches normal mode.
// - Each slot lasts 1 ms; each finished reading lands in its register.
// - Each voltage pin has its own programmable upper and lower limit.
// - A pin reading outside its window sets that pin's alarm bit.
// - A temperature reading outside its range sets the temperature alarm.
// - The monitor is off after reset until software sets its enable.
// - Disabled sources are skipped, so the rotation only has enabled ones.
// - Enable, limit, alarm and reading controls sit at indices 0x15-0x1B.
// - After power-up the first two pins sense voltage, others stay normal.
// - Software reaches these registers through the device register port.
`ifndef VTM_REGS_SVH
`define VTM_REGS_SVH

`define VTM_RES_W      8
`define VTM_NSRC       3
`define VTM_SRC_TEMP   2'h2
`define VTM_SLOT_US    1000
`define VTM_CLK_MHZ    100

`define VTM_IDX_CTRL   8'h15
`define VTM_IDX_LIM0   8'h16
`define VTM_IDX_LIM1   8'h17
`define VTM_IDX_LIMT   8'h18
`define VTM_IDX_ALARM  8'h19
`define VTM_IDX_READ   8'h1a
`define VTM_IDX_MASK   8'h1b

`define VTM_CTRL_EN    0
`define VTM_CTRL_SRC   1
`define VTM_CTRL_CUR   8
`define VTM_CTRL_RUN   10
`define VTM_LIM_HI     8
`define VTM_RD_STEP    8

`define VTM_RST_SRC_EN 3'h7
`define VTM_RST_ROUTE  4'h3
`endif

//--- pkg/vtm_pkg.sv
// Types shared by the monitor sequencer.
`include "vtm_regs.svh"
package vtm_pkg;
   typedef enum logic [1:0] {
      VTM_OFF   = 2'h0,
      VTM_START = 2'h1,
      VTM_MEAS  = 2'h3
   } vtm_fsm_e;

   typedef logic [`VTM_RES_W-1:0] vtm_res_t;

   typedef struct packed {
      vtm_fsm_e                     fsm;
      logic                         mon_en;
      logic [`VTM_NSRC-1:0]         src_en;
      logic [`VTM_NSRC-1:0][7:0]    lim_lo;
      logic [`VTM_NSRC-1:0][7:0]    lim_hi;
      logic [`VTM_NSRC-1:0][7:0]    rd;
      logic [`VTM_NSRC-1:0]         sts;
      logic [`VTM_NSRC-1:0]         mask;
      logic [1:0]                   src;
      logic                         conv;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
      logic                         irq;
      logic [3:0]                   route;
   } vtm_state_s;
endpackage : vtm_pkg

//--- rtl/vtm_slot_timer.sv
// Measurement slot timer that pulses once per slot while running.
`timescale 1ns/1ns
`default_nettype none
module vtm_slot_timer #(
   parameter int unsigned SLOT_CYC = 100000
) (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Control and slot pulse.
   input  wire logic run,
   output var  logic tick
);
   localparam int unsigned CW = $clog2(SLOT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(SLOT_CYC - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } vtm_tmr_s;

   vtm_tmr_s tq;
   vtm_tmr_s td;

   always_comb begin
      td = tq;
      td.tick = 1'b0;
      if (!run) begin
         td.cnt = '0;
      end else if (tq.cnt == LAST) begin
         td.cnt  = '0;
         td.tick = 1'b1;
      end else begin
         td.cnt = tq.cnt + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tq <= '0;
      end else begin
         tq <= td;
      end
   end

   assign tick = tq.tick;
endmodule : vtm_slot_timer
`default_nettype wire

//--- test/vtm_sense_model.sv
// Behavioural converter front end that answers each conversion request.
`timescale 1ns/1ns
`default_nettype none
module vtm_sense_model (
   // Clock and reset.
   input  wire logic            pclk,
   input  wire logic            presetn,
   // Conversion handshake.
   input  wire logic [1:0]      sense_sel,
   input  wire logic            conv_start,
   output var  logic            sense_done,
   output var  logic [7:0]      sense_data,
   // Answer latency and level seen on each source.
   input  wire logic [3:0]      lat,
   input  wire logic [2:0][7:0] level
);
   logic [3:0] cnt_q;
   // Outside the done pulse the data bus toggles, so no stale value passes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         sense_done <= 1'b0;
         sense_data <= 8'h00;
      end else begin
         sense_done <= 1'b0;
         sense_data <= ~sense_data;
         if (conv_start) begin
            cnt_q <= lat;
         end else if (cnt_q == 4'h1) begin
            cnt_q <= 4'h0;
            sense_done <= 1'b1;
            sense_data <= level[sense_sel];
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule : vtm_sense_model
`default_nettype wire

//--- test/vtm_sequencer_bench.sv
// Register-level testbench of the monitor sequencer.
`timescale 1ns/1ns
`default_nettype none
module vtm_sequencer_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        normal_mode, conv_start, sense_done, irq, err;
   logic [1:0]  sense_sel;
   logic [7:0]  sense_data;
   logic [3:0]  pin_sense_route, lat;
   logic [2:0]  alarm;
   logic [2:0][7:0] level;
   int          error_cnt, check_count, cyc;
   logic [1:0]  sel_q[$];
   int          cyc_q[$];

   vtm_sequencer #(.SLOT_CYC(20)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .normal_mode(normal_mode),
      .sense_sel(sense_sel), .conv_start(conv_start),
      .sense_done(sense_done), .sense_data(sense_data),
      .pin_sense_route(pin_sense_route), .alarm(alarm), .irq(irq));
   vtm_sense_model i_model (.pclk(pclk), .presetn(presetn),
      .sense_sel(sense_sel), .conv_start(conv_start),
      .sense_done(sense_done), .sense_data(sense_data), .lat(lat),
      .level(level));

   always #5 pclk = ~pclk;

   // Logs every slot start with its source and cycle number.
   always @(posedge pclk) begin
      cyc++;
      if (conv_start === 1'b1) begin
         sel_q.push_back(sense_sel);
         cyc_q.push_back(cyc);
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
      chk("read error flag", 32'h0000_0000, {31'h0, err});
   endtask : rdc

   task automatic slots(input int n);
      sel_q.delete();
      cyc_q.delete();
      repeat (n) @(posedge pclk);
   endtask : slots

   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end

   initial begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      normal_mode = 1;
      lat = 4'h1;
      level = {8'h20, 8'h50, 8'h50};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("route", 32'h0000_0003, {28'h0, pin_sense_route});
      rdc("ctrl reset", 12'h054, 32'h0000_000E);
      apb(1'b0, 12'h050, 32'h0000_0000);
      chk("unmapped low", 32'h0000_0001, {31'h0, err});
      apb(1'b1, 12'h070, 32'h0000_0001);
      chk("unmapped high", 32'h0000_0001, {31'h0, err});
      apb(1'b1, 12'h058, 32'h0000_8010);
      apb(1'b1, 12'h05C, 32'h0000_4020);
      apb(1'b1, 12'h060, 32'h0000_6030);
      apb(1'b1, 12'h06C, 32'h0000_0007);
      rdc("pin2 limits", 12'h05C, 32'h0000_4020);
      slots(30);
      chk("idle before enable", 32'h0, sel_q.size());
      normal_mode <= 1'b0;
      apb(1'b1, 12'h054, 32'h0000_000F);
      slots(30);
      chk("idle before normal", 32'h0, sel_q.size());
      normal_mode <= 1'b1;
      slots(90);
      chk("slot count", 32'h5, sel_q.size());
      chk("order", 32'h18, {sel_q[0], sel_q[1], sel_q[2], sel_q[3]});
      chk("slot length", 32'd20, cyc_q[1] - cyc_q[0]);
      rdc("readings", 12'h068, 32'h0020_5050);
      chk("alarms", 32'h6, {29'h0, alarm});
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, 12'h054, 32'h0000_000E);
      slots(30);
      chk("stopped", 32'h0, sel_q.size());
      rdc("ctrl stopped", 12'h054, 32'h0000_010E);
      apb(1'b1, 12'h064, 32'h0000_0002);
      @(posedge pclk);
      chk("clear one", 32'h4, {29'h0, alarm});
      apb(1'b1, 12'h06C, 32'h0000_0003);
      @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, 12'h064, 32'h0000_0004);
      rdc("alarm clear", 12'h064, 32'h0000_0000);
      lat <= 4'hF;
      level <= {8'h20, 8'h50, 8'h05};
      apb(1'b1, 12'h054, 32'h0000_000B);
      slots(70);
      chk("skip count", 32'h4, sel_q.size());
      chk("skip order", 32'h08, {sel_q[0], sel_q[1], sel_q[2]});
      rdc("new reading", 12'h068, 32'h0020_5005);
      rdc("ctrl running", 12'h054, 32'h0000_060B);
      chk("low alarm", 32'h5, {29'h0, alarm});
      chk("irq unmasked", 32'h1, {31'h0, irq});
      complete_run();
   end
endmodule : vtm_sequencer_bench
`default_nettype wire
